// [ocel_evbuf.sv]
// far-side event buffer model: counts events and keeps the last
`timescale 1ns/1ps
module ocel_evbuf
   import ocel_pkg::*;
(
   input wire logic sys_clk_in, // clock
   input wire ocel_event_t ev_in, // event from the logger
   output int count_out, // events taken so far
   output ocel_event_t last_out // most recent event
);
   initial count_out = 0;
   // the buffer never stalls, so every valid pulse must be caught here
   always @(posedge sys_clk_in) begin
      if (ev_in.valid === 1'b1) begin
         count_out <= count_out + 1;
         last_out <= ev_in;
      end
   end
endmodule

// [ocel_pkg.sv]
// package: constants, register map and carrier types of the overcurrent event logger
package ocel_pkg;
   localparam int OCEL_STAGES = 4;
   localparam int OCEL_SIGS = 6;
   localparam int OCEL_EVBITS = 12;
   localparam int OCEL_REC_DEPTH = 12;
   localparam logic [3:0] OCEL_REC_LAST = 4'hB;
   localparam int OCEL_AW = 8;

   // timing: clock period, millisecond time base, program cycle
   localparam int OCEL_CLK_PERIOD_NS = 4;
   localparam int OCEL_MS_NS = 1000000;
   localparam int OCEL_CYC_PER_MS = OCEL_MS_NS / OCEL_CLK_PERIOD_NS;
   localparam int OCEL_PROG_CYCLE_MS = 5;

   // pick-up release and ratio scaling (ratio reported in 0.01 steps)
   localparam logic [6:0] OCEL_RELEASE_PCT = 7'h61;
   localparam logic [6:0] OCEL_RATIO_SCALE = 7'h64;

   // register byte addresses
   localparam logic [OCEL_AW-1:0] OCEL_CTRL_ADDR = 8'h00;
   localparam logic [OCEL_AW-1:0] OCEL_HLIM_ADDR = 8'h04;
   localparam logic [OCEL_AW-1:0] OCEL_STAT_ADDR = 8'h08;
   localparam logic [OCEL_AW-1:0] OCEL_ANGLE_ADDR = 8'h0C;
   localparam logic [OCEL_AW-1:0] OCEL_EXPT_ADDR = 8'h10;
   localparam logic [OCEL_AW-1:0] OCEL_RSEL_ADDR = 8'h14;
   localparam logic [OCEL_AW-1:0] OCEL_RTS_ADDR = 8'h18;
   localparam logic [OCEL_AW-1:0] OCEL_RINFO_ADDR = 8'h1C;
   localparam logic [OCEL_AW-1:0] OCEL_RCUR_ADDR = 8'h20;
   localparam logic [OCEL_AW-1:0] OCEL_RPRE_ADDR = 8'h24;
   localparam logic [OCEL_AW-1:0] OCEL_RANG_ADDR = 8'h28;
   localparam logic [OCEL_AW-1:0] OCEL_PSET_ADDR = 8'h40;
   localparam logic [OCEL_AW-1:0] OCEL_LIVE_ADDR = 8'h50;
   localparam logic [OCEL_AW-1:0] OCEL_STAGE_MASK = 8'hF3;

   // control register fields
   localparam int OCEL_INRUSH_BIT = 0;
   localparam int OCEL_FORCE_BIT = 1;
   localparam int OCEL_FCODE_LSB = 2;
   localparam int OCEL_SWBLK_BIT = 4;
   localparam int OCEL_EVSEL_LSB = 5;
   localparam logic [31:0] OCEL_CTRL_RST = 32'h0000_0060;
   localparam logic [15:0] OCEL_HLIM_RST = 16'h0001;
   localparam logic [15:0] OCEL_PSET_RST = 16'h0078;

   localparam logic [1:0] OCEL_RESP_OKAY = 2'h0;
   localparam logic [1:0] OCEL_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      OCEL_F_NORMAL = 2'b00,
      OCEL_F_START = 2'b01,
      OCEL_F_TRIP = 2'b10,
      OCEL_F_BLOCKED = 2'b11
   } ocel_force_t;

   // live process data from the measurement side
   typedef struct packed {
      logic [15:0] imax;
      logic [15:0] angle;
      logic [15:0] exp_time;
      logic [15:0] harm2;
      logic [15:0] pre20;
      logic [15:0] pre200;
      logic [3:0] fault;
      logic [2:0] sg;
   } ocel_meas_t;

   // one operation record
   typedef struct packed {
      logic [31:0] ts;
      logic [3:0] code;
      logic [3:0] fault;
      logic [15:0] pre20;
      logic [15:0] fcur;
      logic [15:0] pre200;
      logic [15:0] remain;
      logic [2:0] sg;
      logic [15:0] angle;
   } ocel_rec_t;

   // event handed to the common event buffer
   typedef struct packed {
      logic valid;
      logic [1:0] group;
      logic [3:0] code;
      logic [31:0] ts;
      logic [15:0] cur;
      logic [3:0] fault;
   } ocel_event_t;
endpackage

// [ocel_top.sv]
// overcurrent stage blocking, status, event and record logic with AXI4-Lite registers
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// - blocking input sampled once per program cycle, held for that cycle
// - blocking comes from a dedicated input fed by the blocking matrix
// - pick-up without blocking raises START and starts the trip timing
// - pick-up with blocking raises BLOCKED instead, no further processing
// - blocking after START clears START and runs release like pick-up dropout
// - inrush blocking enable setting, 0 off 1 on, default off
// - inrush blocks when second harmonic ratio reaches limit, 0.01 percent steps
// - blocking gives notification and event with start current and fault type
// - software switch drives blocking while stage forcing is enabled
// - events on every START, TRIP, BLOCKED change; ON, OFF or both stored
// - four independent stages, each with its own event group
// - on/off events for start, trip, block, no-voltage, live angle, voltage memory
// - twelve most recent records kept per stage
// - record written only on ON edge of START, TRIP or BLOCKED
// - record holds time, event, fault, pre, fault, average current, remaining, group, angle
// - live operating angle reported in 0.01 degree
// - expected operating time reported in 5 ms steps, follows current
// - remaining time to trip reported while counting
// - ratio of highest current to pick-up setting reported live
// - force status 0 normal 1 start 2 trip 3 blocked, only when forcing
// - pick-up releases only below 97 percent of setting
module ocel_top
   import ocel_pkg::*;
#(
   parameter int CYC_PER_MS = OCEL_CYC_PER_MS
) (
   input wire logic sys_clk_in, // 250 MHz clock
   input wire logic sys_rst_in, // async reset, active high
   input wire logic cycle_tick_in, // one-cycle pulse, start of program cycle
   input wire logic [3:0] blk_matrix_in, // per-stage blocking from blocking matrix
   input wire logic [3:0] novolt_in, // per-stage no-voltage blocking level
   input wire logic [3:0] live_angle_in, // per-stage live angle measuring level
   input wire logic [3:0] voltmem_in, // per-stage voltage memory in use level
   input wire ocel_meas_t meas_in, // live process data
   input wire logic [OCEL_AW-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [OCEL_AW-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic [3:0] start_out, // per-stage START
   output logic [3:0] trip_out, // per-stage TRIP
   output logic [3:0] blocked_out, // per-stage BLOCKED
   output logic notify_out, // display notification on blocking, one pulse
   output ocel_event_t event_out // one event per cycle, valid is a pulse
);

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [OCEL_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [15:0] hlim;
      logic [3:0][15:0] pset;
      logic [5:0] rsel;
      logic [17:0] ms_div;
      logic [31:0] ms_cnt;
      logic [3:0] blk_smp;
      logic [3:0] pu;
      logic [3:0] start;
      logic [3:0] trip;
      logic [3:0] blocked;
      logic [3:0][15:0] remain;
      logic [3:0] start_o;
      logic [3:0] trip_o;
      logic [3:0] blk_o;
      logic [3:0][2:0] aux_q;
      logic [3:0][OCEL_EVBITS-1:0] pend;
      logic notify;
      ocel_event_t ev;
      ocel_rec_t [3:0][OCEL_REC_DEPTH-1:0] rec;
      logic [3:0][3:0] wptr;
   } ocel_state_t;

   ocel_state_t st_q, st_d;
   logic [3:0] blk_now;
   logic [3:0] pu_set;
   logic [3:0] pu_rel;
   logic force_en;
   ocel_force_t fcode;
   logic [1:0] evsel;

   // settings decode and the blocking decision per stage
   assign force_en = st_q.ctrl[OCEL_FORCE_BIT];
   assign fcode = ocel_force_t'(st_q.ctrl[OCEL_FCODE_LSB +: 2]);
   assign evsel = st_q.ctrl[OCEL_EVSEL_LSB +: 2];
   for (genvar g = 0; g < OCEL_STAGES; g++) begin : g_stage
      assign blk_now[g] = blk_matrix_in[g]
         | (st_q.ctrl[OCEL_INRUSH_BIT] & (meas_in.harm2 >= st_q.hlim))
         | (force_en & st_q.ctrl[OCEL_SWBLK_BIT]);
      assign pu_set[g] = meas_in.imax > st_q.pset[g];
      // release threshold scaled so no division is needed
      assign pu_rel[g] = (23'(meas_in.imax) * 23'(OCEL_RATIO_SCALE))
         < (23'(st_q.pset[g]) * 23'(OCEL_RELEASE_PCT));
   end

   // next-state logic: bus slave, stage sequencing, events and records
   always_comb begin
      logic [3:0] on_edge;
      logic [2:0] now_o;
      logic [2:0] old_o;
      logic [5:0] ev_aux;
      logic [5:0] now_all;
      logic found;
      logic [15:0] lsrc;
      logic [23:0] quot;
      logic [1:0] sst;
      logic [3:0] sslot;
      ocel_rec_t rr;
      on_edge = 4'h0;
      now_o = 3'h0;
      old_o = 3'h0;
      ev_aux = 6'h00;
      now_all = 6'h00;
      found = 1'b0;
      lsrc = 16'h0000;
      quot = 24'h000000;
      sst = st_q.rsel[1:0];
      sslot = st_q.rsel[5:2];
      rr = '0;
      st_d = st_q;
      st_d.notify = 1'b0;
      st_d.ev.valid = 1'b0;

      // millisecond time stamp base
      if (st_d.ms_div == 18'(CYC_PER_MS - 1)) begin
         st_d.ms_div = 18'h00000;
         st_d.ms_cnt = st_q.ms_cnt + 32'h1;
      end else begin
         st_d.ms_div = st_q.ms_div + 18'h1;
      end

      // write channel: address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
         st_d.awready = 1'b0;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
         st_d.wready = 1'b0;
      end
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
         st_d.bvalid = 1'b1;
         st_d.bresp = OCEL_RESP_OKAY;
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         if (st_q.awaddr == OCEL_CTRL_ADDR) begin
            for (int b = 0; b < 4; b++) begin
               if (st_q.wstrb[b]) st_d.ctrl[b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
         end else if (st_q.awaddr == OCEL_HLIM_ADDR) begin
            for (int b = 0; b < 2; b++) begin
               if (st_q.wstrb[b]) st_d.hlim[b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
         end else if (st_q.awaddr == OCEL_RSEL_ADDR) begin
            if (st_q.wstrb[0]) st_d.rsel = st_q.wdata[5:0];
         end else if ((st_q.awaddr & OCEL_STAGE_MASK) == OCEL_PSET_ADDR) begin
            for (int b = 0; b < 2; b++) begin
               if (st_q.wstrb[b]) st_d.pset[st_q.awaddr[3:2]][b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
         end else begin
            st_d.bresp = OCEL_RESP_SLVERR;
         end
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
         st_d.awready = 1'b1;
         st_d.wready = 1'b1;
      end

      // read channel: answer one cycle after the address is taken
      if (s_axi_arvalid && st_q.arready) begin
         st_d.arready = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp = OCEL_RESP_OKAY;
         st_d.rdata = 32'h0;
         if (sslot <= OCEL_REC_LAST) rr = st_q.rec[sst][sslot];
         case (s_axi_araddr)
            OCEL_CTRL_ADDR: st_d.rdata = st_q.ctrl;
            OCEL_HLIM_ADDR: st_d.rdata = {16'h0, st_q.hlim};
            OCEL_STAT_ADDR: st_d.rdata = {20'h0, st_q.blk_o, st_q.trip_o, st_q.start_o};
            OCEL_ANGLE_ADDR: st_d.rdata = {16'h0, meas_in.angle};
            OCEL_EXPT_ADDR: st_d.rdata = {16'h0, meas_in.exp_time};
            OCEL_RSEL_ADDR: st_d.rdata = {22'h0, st_q.wptr[sst], st_q.rsel};
            OCEL_RTS_ADDR: st_d.rdata = rr.ts;
            OCEL_RINFO_ADDR: st_d.rdata = {21'h0, rr.sg, rr.fault, rr.code};
            OCEL_RCUR_ADDR: st_d.rdata = {rr.pre20, rr.fcur};
            OCEL_RPRE_ADDR: st_d.rdata = {rr.pre200, rr.remain};
            OCEL_RANG_ADDR: st_d.rdata = {16'h0, rr.angle};
            default: begin
               if ((s_axi_araddr & OCEL_STAGE_MASK) == OCEL_PSET_ADDR) begin
                  st_d.rdata = {16'h0, st_q.pset[s_axi_araddr[3:2]]};
               end else if ((s_axi_araddr & OCEL_STAGE_MASK) == OCEL_LIVE_ADDR) begin
                  lsrc = st_q.pset[s_axi_araddr[3:2]];
                  // zero setting would divide by zero; saturate instead
                  if (lsrc == 16'h0000) quot = 24'hFFFFFF;
                  else quot = (24'(meas_in.imax) * 24'(OCEL_RATIO_SCALE)) / 24'(lsrc);
                  if (quot[23:16] != 8'h00) quot[15:0] = 16'hFFFF;
                  st_d.rdata = {quot[15:0], st_q.remain[s_axi_araddr[3:2]]};
               end else begin
                  st_d.rresp = OCEL_RESP_SLVERR;
               end
            end
         endcase
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end

      // event emission, lowest pending bit first; cleared before new sets so set wins
      for (int k = 0; k < OCEL_STAGES * OCEL_EVBITS; k++) begin
         if (!found && st_q.pend[k / OCEL_EVBITS][k % OCEL_EVBITS]) begin
            found = 1'b1;
            st_d.pend[k / OCEL_EVBITS][k % OCEL_EVBITS] = 1'b0;
            st_d.ev.valid = 1'b1;
            st_d.ev.group = 2'(k / OCEL_EVBITS);
            st_d.ev.code = 4'(k % OCEL_EVBITS);
            st_d.ev.ts = st_q.ms_cnt;
            st_d.ev.cur = meas_in.imax;
            st_d.ev.fault = meas_in.fault;
         end
      end

      for (int i = 0; i < OCEL_STAGES; i++) begin
         // stage sequencing runs once per program cycle
         if (cycle_tick_in) begin
            st_d.blk_smp[i] = blk_now[i];
            if (pu_set[i]) st_d.pu[i] = 1'b1;
            else if (pu_rel[i]) st_d.pu[i] = 1'b0;
            if (!st_d.pu[i]) begin
               st_d.start[i] = 1'b0;
               st_d.trip[i] = 1'b0;
               st_d.blocked[i] = 1'b0;
               st_d.remain[i] = 16'h0000;
            end else if (!st_q.pu[i]) begin
               if (blk_now[i]) begin
                  st_d.blocked[i] = 1'b1;
               end else begin
                  st_d.start[i] = 1'b1;
                  st_d.remain[i] = meas_in.exp_time;
               end
            end else if (st_q.start[i] && blk_now[i]) begin
               // same path as a pick-up dropout
               st_d.start[i] = 1'b0;
               st_d.trip[i] = 1'b0;
               st_d.remain[i] = 16'h0000;
            end else if (st_q.start[i] && !st_q.trip[i]) begin
               if (st_q.remain[i] == 16'h0000) st_d.trip[i] = 1'b1;
               else st_d.remain[i] = st_q.remain[i] - 16'h1;
            end
         end

         // forced status overrides the outputs only while forcing is enabled; normal code passes the stage through
         if (force_en && fcode != OCEL_F_NORMAL) begin
            now_o = {fcode == OCEL_F_BLOCKED, fcode == OCEL_F_TRIP, fcode == OCEL_F_START};
         end else begin
            now_o = {st_d.blocked[i], st_d.trip[i], st_d.start[i]};
         end
         old_o = {st_q.blk_o[i], st_q.trip_o[i], st_q.start_o[i]};
         st_d.start_o[i] = now_o[0];
         st_d.trip_o[i] = now_o[1];
         st_d.blk_o[i] = now_o[2];
         st_d.aux_q[i] = {voltmem_in[i], live_angle_in[i], novolt_in[i]};
         if (now_o[2] && !old_o[2]) st_d.notify = 1'b1;

         // event bits: even index ON, odd index OFF, per signal
         now_all = {st_d.aux_q[i], now_o};
         ev_aux = now_all ^ {st_q.aux_q[i], old_o};
         for (int j = 0; j < OCEL_SIGS; j++) begin
            if (ev_aux[j]) begin
               if (now_all[j]) begin
                  if (evsel[0]) st_d.pend[i][2*j] = 1'b1;
               end else begin
                  if (evsel[1]) st_d.pend[i][2*j+1] = 1'b1;
               end
            end
         end

         // one record per cycle with any ON edge; trip code wins, then start, then blocked, when several rise together
         on_edge = {1'b0, now_o & ~old_o};
         if (on_edge != 4'h0) begin
            st_d.rec[i][st_q.wptr[i]].ts = st_q.ms_cnt;
            st_d.rec[i][st_q.wptr[i]].code = on_edge[1] ? 4'h2 : (on_edge[0] ? 4'h0 : 4'h4);
            st_d.rec[i][st_q.wptr[i]].fault = meas_in.fault;
            st_d.rec[i][st_q.wptr[i]].pre20 = meas_in.pre20;
            st_d.rec[i][st_q.wptr[i]].fcur = meas_in.imax;
            st_d.rec[i][st_q.wptr[i]].pre200 = meas_in.pre200;
            st_d.rec[i][st_q.wptr[i]].remain = st_d.remain[i];
            st_d.rec[i][st_q.wptr[i]].sg = meas_in.sg;
            st_d.rec[i][st_q.wptr[i]].angle = meas_in.angle;
            // wrap to slot 0 so the oldest entry is replaced
            if (st_q.wptr[i] == OCEL_REC_LAST) st_d.wptr[i] = 4'h0;
            else st_d.wptr[i] = st_q.wptr[i] + 4'h1;
         end
      end
   end

   // single state register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q <= '0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.ctrl <= OCEL_CTRL_RST;
         st_q.hlim <= OCEL_HLIM_RST;
         st_q.pset <= {OCEL_STAGES{OCEL_PSET_RST}};
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
   assign start_out = st_q.start_o;
   assign trip_out = st_q.trip_o;
   assign blocked_out = st_q.blk_o;
   assign notify_out = st_q.notify;
   assign event_out = st_q.ev;

   default clocking ck @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   blk_sample_hold_a: assert property (!cycle_tick_in |=> $stable(st_q.blk_smp)) else $error("block sample moved");
   start_clean_a: assert property (cycle_tick_in && !force_en && pu_set[0] && !st_q.pu[0] && !blk_now[0]
      |=> start_out[0] && !blocked_out[0]) else $error("start missing");
   blocked_not_start_a: assert property (cycle_tick_in && !force_en && pu_set[0] && !st_q.pu[0] && blk_now[0]
      |=> blocked_out[0] && !start_out[0] ##1 !start_out[0]) else $error("blocked start wrong");
   late_block_a: assert property (cycle_tick_in && st_q.start[0] && blk_now[0]
      |=> !st_q.start[0] && st_q.remain[0] == 16'h0000) else $error("late block kept start");
   inrush_block_a: assert property (cycle_tick_in && st_q.ctrl[OCEL_INRUSH_BIT] && meas_in.harm2 >= st_q.hlim
      |=> st_q.blk_smp == 4'hF) else $error("inrush not blocking");
   pickup_hyst_a: assert property (cycle_tick_in && st_q.pu[0] && !pu_rel[0] |=> st_q.pu[0]) else $error("early release");
   force_trip_a: assert property (force_en && fcode == OCEL_F_TRIP |=> trip_out == 4'hF && start_out == 4'h0)
      else $error("force trip ignored");
   rec_ptr_wrap_a: assert property (st_q.wptr[0] == OCEL_REC_LAST && !force_en && $rose(st_q.start_o[0])
      |-> $past(st_q.wptr[0]) == 4'hA) else $error("record pointer slip");
   ev_from_pend_a: assert property (event_out.valid |-> $past(st_q.pend != '0)) else $error("spurious event");
   notify_block_a: assert property ($rose(blocked_out[0]) |-> notify_out) else $error("no block notify");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule

// [ocel_top_test.sv]
// self-checking bench for the overcurrent event logger
`timescale 1ns/1ps
module ocel_top_test
   import ocel_pkg::*;
;
   logic clk = 0, rst = 1, tick = 0, awv = 0, wv = 0, arv = 0;
   logic awr, wrr, bv, arr, rv, ntf;
   logic [3:0] blk = 0, nv = 0, la = 0, vm = 0, st, tr, bl;
   logic [7:0] aw = 0, ar = 0;
   logic [31:0] wd = 0, rd, rdat;
   logic [1:0] br, rr, rsp;
   ocel_meas_t meas = '0;
   ocel_event_t ev, last;
   int num_errors = 0, tests_run = 0, cyc = 0, cnt, evn, nfy = 0;

   always #2 clk = ~clk;

   // short millisecond parameter makes the time stamp advance every 10 clocks
   ocel_top #(.CYC_PER_MS(10)) u_dut (.sys_clk_in(clk), .sys_rst_in(rst),
      .cycle_tick_in(tick), .blk_matrix_in(blk), .novolt_in(nv),
      .live_angle_in(la), .voltmem_in(vm), .meas_in(meas),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(1'b1), .start_out(st),
      .trip_out(tr), .blocked_out(bl), .notify_out(ntf), .event_out(ev));
   ocel_evbuf u_evbuf (.sys_clk_in(clk), .ev_in(ev), .count_out(cnt), .last_out(last));

   // notification pulses seen so far
   always @(posedge clk) begin
      if (ntf === 1'b1) nfy++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // bready and rready stay high, so the answer edge ends each wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (1) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
         if (bv) break;
      end
      rsp = br;
   endtask

   task automatic rdr(input logic [7:0] a);
      ar <= a;
      arv <= 1'b1;
      while (1) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      rdat = rd;
      rsp = rr;
   endtask

   // one program cycle tick, then let the outputs settle
   task automatic tk();
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   function automatic logic [31:0] stat();
      return {20'h0, bl, tr, st};
   endfunction

   task automatic t_regs();
      rdr(OCEL_CTRL_ADDR);
      chk(rdat, 32'h0000_0060);
      rdr(OCEL_HLIM_ADDR);
      chk(rdat, 32'h0000_0001);
      rdr(OCEL_PSET_ADDR);
      chk(rdat, 32'h0000_0078);
      rdr(8'h30);
      chk({30'h0, rsp}, 32'h2);
      wr(OCEL_STAT_ADDR, 32'hFFF);
      chk({30'h0, rsp}, 32'h2);
   endtask

   task automatic t_events();
      evn = cnt;
      nv <= 4'h4;
      la <= 4'h1;
      vm <= 4'h8;
      repeat (6) @(posedge clk);
      chk(32'(cnt - evn), 32'h3);
      chk({26'h0, last.group, last.code}, 32'h3A);
      nv <= 4'h0;
      la <= 4'h0;
      vm <= 4'h0;
      repeat (6) @(posedge clk);
      chk({26'h0, last.group, last.code}, 32'h3B);
   endtask

   task automatic t_pickup();
      meas.imax <= 16'h0080;
      meas.exp_time <= 16'h0002;
      meas.fault <= 4'h3;
      meas.sg <= 3'h2;
      tk();
      chk(stat(), 32'h00F);
      rdr(OCEL_LIVE_ADDR);
      chk({16'h0, rdat[31:16]}, 32'h006A);
      repeat (2) tk();
      chk(stat(), 32'h00F);
      tk();
      chk(stat(), 32'h0FF);
      meas.imax <= 16'h0075;
      tk();
      chk(stat(), 32'h0FF);
      blk <= 4'h1;
      tk();
      chk({24'h0, tr, st}, 32'hEE);
      meas.imax <= 16'h0074;
      tk();
      chk({24'h0, tr, st}, 32'h00);
      meas.imax <= 16'h0080;
      tk();
      chk(stat(), 32'h10E);
      chk(32'(nfy), 32'h1);
      blk <= 4'h0;
      meas.imax <= 16'h0000;
      tk();
      chk(stat(), 32'h000);
      // a block pulse between ticks must be missed
      blk <= 4'hF;
      @(posedge clk);
      blk <= 4'h0;
      meas.imax <= 16'h0080;
      tk();
      chk(stat(), 32'h00F);
      meas.imax <= 16'h0000;
      tk();
   endtask

   task automatic t_record();
      logic [3:0] code [3] = '{4'h0, 4'h2, 4'h4};
      wr(OCEL_RSEL_ADDR, 32'h0);
      rdr(OCEL_RINFO_ADDR);
      chk(rdat, 32'h0000_0230);
      foreach (code[i]) begin
         wr(OCEL_RSEL_ADDR, 32'(i) << 2);
         rdr(OCEL_RINFO_ADDR);
         chk({28'h0, rdat[3:0]}, {28'h0, code[i]});
      end
   endtask

   task automatic t_force();
      logic [31:0] cv [2] = '{32'h72, 32'h61};
      for (int c = 1; c < 4; c++) begin
         wr(OCEL_CTRL_ADDR, 32'h62 | (c << 2));
         repeat (2) @(posedge clk);
         chk(stat(), 32'hF << (4 * (c - 1)));
      end
      meas.harm2 <= 16'h0001;
      foreach (cv[i]) begin
         wr(OCEL_CTRL_ADDR, cv[i]);
         meas.imax <= 16'h0080;
         tk();
         chk(stat(), 32'hF00);
         meas.imax <= 16'h0000;
         tk();
      end
   endtask

   // four more stage 0 pickups fill the history and wrap onto slot 0
   task automatic t_wrap();
      wr(OCEL_CTRL_ADDR, OCEL_CTRL_RST);
      meas.fault <= 4'h5;
      repeat (4) begin
         meas.imax <= 16'h0080;
         tk();
         meas.imax <= 16'h0000;
         tk();
      end
      wr(OCEL_RSEL_ADDR, 32'h0);
      rdr(OCEL_RSEL_ADDR);
      chk(rdat, 32'h0000_0040);
      rdr(OCEL_RINFO_ADDR);
      chk(rdat, 32'h0000_0250);
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, far above the fewer than 200 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_events();
      t_pickup();
      t_record();
      t_force();
      t_wrap();
      summarize();
   end
endmodule
